// ---- hdl/wdog_core.sv ----
`timescale 1ns/100ps
`include "wdog_defines.svh"

// Summary of operation
// - Any reset restores maximum reload and counter
// - Count only after reset released, refresh low
// - Timeout issues reset pulse, reload back maximum
// - Valid refresh pulse reloads counter, restarts interval
// - Wide first pulse programs counter and reload
// - Program only above threshold, below maximum
// - Programming locked until the next reset
// - Refresh falling resumes counting toward new limit
// - Later short pulses reload with programmed value
// - Refresh held too long gives immediate reset
// - Inhibit high suppresses all watchdog resets

// ----------------------------------------------------------------------
// Watchdog core
// ----------------------------------------------------------------------
module wdog_core #(
  parameter int TICK_CYCLES   = `WDOG_TICK_CYCLES,          // Clocks per tick
  parameter int CNT_W         = `WDOG_CNT_WIDTH,            // Counter width
  parameter int MAX_TIMEOUT   = `WDOG_MAX_TIMEOUT_TICKS,    // Ticks
  parameter int PROG_THRESH   = `WDOG_PROG_THRESHOLD_TICKS, // Ticks
  parameter int RESET_PULSE   = `WDOG_RESET_PULSE_TICKS     // Ticks
) (
  input  wire logic             MCLK_IN,         // System clock, 100 MHz
  input  wire logic             RST_B_IN,        // Power-on/undervoltage reset
  input  wire logic             WD_REFRESH_IN,   // Refresh line from host
  input  wire logic             WD_INHIBIT_IN,   // Inhibit line, high = inhibit
  output logic                  RESET_B_OUT,     // Reset to host, active low
  output logic                  PROGRAMMED_OUT,  // Reload value was programmed
  output logic      [CNT_W-1:0] RELOAD_OUT       // Stored reload value, ticks
);

  // ----------------------------------------------------------------------
  // Constants at counter width
  // ----------------------------------------------------------------------
  // shared tick units
  localparam logic [CNT_W-1:0] MAX_C   = CNT_W'(MAX_TIMEOUT);
  localparam logic [CNT_W-1:0] THR_C   = CNT_W'(PROG_THRESH);
  localparam logic [CNT_W-1:0] PULSE_C = CNT_W'(RESET_PULSE);
  localparam logic [CNT_W-1:0] SAT_C   = '1;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  wdog_pkg::wd_state_e state_q;      // Sequencer state
  wdog_pkg::wd_state_e state_d;
  logic [CNT_W-1:0]    count_q;      // Interval or reset-pulse count
  logic [CNT_W-1:0]    count_d;
  logic [CNT_W-1:0]    width_q;      // Measured refresh pulse width
  logic [CNT_W-1:0]    width_d;
  logic [CNT_W-1:0]    reload_q;     // Stored reload value
  logic [CNT_W-1:0]    reload_d;
  logic                prog_q;       // Reload programmed since reset
  logic                prog_d;
  logic                reset_b_q;    // Registered reset to host
  logic                reset_b_d;
  logic                refresh_d_q;  // Refresh one cycle late, for edges
  logic [1:0]          pins_s;       // Synchronised pins
  logic                refresh_s;    // Synchronised refresh
  logic                inhibit_s;    // Synchronised inhibit
  logic                rise;         // Refresh rising edge
  logic                fall;         // Refresh falling edge
  logic                tick;         // Time-base tick
  logic                restart;      // Realign tick phase

  // ----------------------------------------------------------------------
  // Pin synchronisers and time base
  // ----------------------------------------------------------------------
  // Both pins come from the host's domain, so they pass two flops
  wdog_sync2 #(
    .WIDTH    (2)
  ) u_sync (
    .clk_in   (MCLK_IN),
    .rst_b_in (RST_B_IN),
    .async_in ({WD_INHIBIT_IN, WD_REFRESH_IN}),
    .sync_out (pins_s)
  );

  assign refresh_s = pins_s[0];
  assign inhibit_s = pins_s[1];
  assign rise      = refresh_s & ~refresh_d_q;
  assign fall      = ~refresh_s & refresh_d_q;

  // Restarting the tick phase on every edge keeps width and interval
  // measurements free of up to one tick of phase error
  assign restart   = rise | fall;

  wdog_tick_gen #(
    .CYCLES     (TICK_CYCLES)
  ) u_tick (
    .clk_in     (MCLK_IN),
    .rst_b_in   (RST_B_IN),
    .restart_in (restart),
    .tick_out   (tick)
  );

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  // Count runs up from zero to the reload value; loading the timer means
  // clearing the count, so the stored reload value is the limit
  always_comb begin
    state_d  = state_q;
    count_d  = count_q;
    width_d  = width_q;
    reload_d = reload_q;
    prog_d   = prog_q;
    case (state_q)
      wdog_pkg::ST_RESET: begin
        reload_d = MAX_C;
        prog_d   = 1'b0;
        width_d  = '0;
        if (count_q >= PULSE_C) begin
          // Pulse done; interval count starts from zero
          state_d = wdog_pkg::ST_WAIT;
          count_d = '0;
        end else if (tick) begin
          count_d = count_q + CNT_W'(1);
        end
      end
      wdog_pkg::ST_WAIT: begin
        if (!refresh_s) begin
          state_d = wdog_pkg::ST_COUNT;
        end
      end
      wdog_pkg::ST_COUNT: begin
        if (count_q >= reload_q) begin
          if (!inhibit_s) begin
            // timeout resets host
            // Reload goes back on entry, so it never lags the reset pin
            state_d  = wdog_pkg::ST_RESET;
            reload_d = MAX_C;
            prog_d   = 1'b0;
          end
          count_d = '0;
        end else if (rise) begin
          state_d = wdog_pkg::ST_HIGH;
          count_d = '0;
          width_d = '0;
        end else if (tick) begin
          count_d = count_q + CNT_W'(1);
        end
      end
      wdog_pkg::ST_HIGH: begin
        if (width_q > reload_q && !inhibit_s) begin
          state_d  = wdog_pkg::ST_RESET;
          count_d  = '0;
          reload_d = MAX_C;
          prog_d   = 1'b0;
        end else if (fall) begin
          state_d = wdog_pkg::ST_COUNT;
          count_d = '0;
          if (!prog_q && width_q > THR_C && width_q < MAX_C) begin
            reload_d = width_q;
            prog_d   = 1'b1;
          end
        end else if (tick && width_q != SAT_C) begin
          // Saturate so an inhibited stuck line never wraps
          width_d = width_q + CNT_W'(1);
        end
      end
      default: begin
        state_d = wdog_pkg::ST_RESET;
        count_d = '0;
      end
    endcase
    reset_b_d = (state_d != wdog_pkg::ST_RESET);
  end

  // ----------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------
  // power-on sets maximum
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_q     <= wdog_pkg::ST_RESET;
      count_q     <= '0;
      width_q     <= '0;
      reload_q    <= CNT_W'(MAX_TIMEOUT);
      prog_q      <= 1'b0;
      reset_b_q   <= 1'b0;
      refresh_d_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      count_q     <= count_d;
      width_q     <= width_d;
      reload_q    <= reload_d;
      prog_q      <= prog_d;
      reset_b_q   <= reset_b_d;
      refresh_d_q <= refresh_s;
    end
  end

  assign RESET_B_OUT    = reset_b_q;
  assign PROGRAMMED_OUT = prog_q;
  assign RELOAD_OUT     = reload_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // Refresh pulse ends while measurement is running
  sequence s_high_fall;
    state_q == wdog_pkg::ST_HIGH && fall && !(width_q > reload_q && !inhibit_s);
  endsequence

  // Pulse qualifies for programming
  sequence s_prog_pulse;
    s_high_fall ##0 (!prog_q && width_q > THR_C && width_q < MAX_C);
  endsequence

  chk_reset_max_reload: assert property (
    state_q == wdog_pkg::ST_RESET |=> reload_q == MAX_C && !prog_q)
    else $error("reload not maximum during reset");

  chk_wait_no_count: assert property (
    state_q == wdog_pkg::ST_WAIT && refresh_s |=> state_q == wdog_pkg::ST_WAIT && count_q == '0)
    else $error("counting began while refresh high");

  chk_timeout_reset: assert property (
    state_q == wdog_pkg::ST_COUNT && count_q >= reload_q && !inhibit_s
    |=> !RESET_B_OUT && reload_q == MAX_C && !prog_q)
    else $error("timeout did not reset host");

  chk_refresh_reload: assert property (
    state_q == wdog_pkg::ST_COUNT && count_q < reload_q && rise
    |=> state_q == wdog_pkg::ST_HIGH && count_q == '0 && RESET_B_OUT)
    else $error("refresh did not reload timer");

  chk_program_load: assert property (
    s_prog_pulse |=> reload_q == $past(width_q) && prog_q && count_q == '0)
    else $error("pulse width not programmed");

  chk_program_once: assert property (
    prog_q && state_d != wdog_pkg::ST_RESET |=> $stable(reload_q))
    else $error("reload changed after programming");

  chk_resume_count: assert property (
    s_high_fall |=> state_q == wdog_pkg::ST_COUNT && count_q == '0)
    else $error("count did not resume after refresh");

  chk_stuck_high: assert property (
    state_q == wdog_pkg::ST_HIGH && width_q > reload_q && !inhibit_s
    |=> !RESET_B_OUT && state_q == wdog_pkg::ST_RESET)
    else $error("stuck refresh did not reset host");

  chk_inhibit_hold: assert property (
    inhibit_s && RESET_B_OUT |=> RESET_B_OUT)
    else $error("reset issued while inhibited");

  // Timeout reached while the inhibit line is high
  sequence s_timeout_inhibited;
    state_q == wdog_pkg::ST_COUNT && count_q >= reload_q && inhibit_s;
  endsequence

  // Pulse ends outside the programming window or after programming
  sequence s_prog_refused;
    s_high_fall ##0 (prog_q || width_q <= THR_C || width_q >= MAX_C);
  endsequence

  chk_program_window: assert property (
    s_high_fall ##0 (!prog_q && (width_q <= THR_C || width_q >= MAX_C)) |=> !prog_q)
    else $error("pulse outside window programmed");

  chk_later_reload: assert property (
    s_prog_refused |=> reload_q == $past(reload_q) && count_q == '0)
    else $error("refused pulse changed reload");

  chk_inhibit_restart: assert property (
    s_timeout_inhibited |=> state_q == wdog_pkg::ST_COUNT && count_q == '0 && RESET_B_OUT)
    else $error("inhibited timeout did not restart");

  chk_count_on_tick: assert property (
    state_q == wdog_pkg::ST_COUNT && count_q < reload_q && !rise && !tick
    |=> $stable(count_q))
    else $error("count moved without a tick");

endmodule : wdog_core

// ---- hdl/wdog_defines.svh ----
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
// System clock period in ns (100 MHz)
`define WDOG_CLK_PERIOD_NS    10
// One internal time-base tick in ns (1 ms)
`define WDOG_TICK_PERIOD_NS   1000000
// Clock cycles per time-base tick, derived from the two figures above
`define WDOG_TICK_CYCLES      (`WDOG_TICK_PERIOD_NS / `WDOG_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Watchdog timing, in time-base ticks
// ----------------------------------------------------------------------
// Longest timeout; also the reload value after every reset
`define WDOG_MAX_TIMEOUT_TICKS    200
// A programming pulse must be wider than this
`define WDOG_PROG_THRESHOLD_TICKS 10
// Length of the reset pulse sent to the host
`define WDOG_RESET_PULSE_TICKS    5
// Width of the tick counters
`define WDOG_CNT_WIDTH            16

`endif

// ---- hdl/wdog_pkg.sv ----
// ----------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------
package wdog_pkg;

  // Watchdog sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,  // Reset pulse to host is driven
    ST_WAIT  = 4'b0010,  // Waiting for refresh line to go low
    ST_COUNT = 4'b0100,  // Counting the watchdog interval
    ST_HIGH  = 4'b1000   // Refresh high, pulse width measured
  } wd_state_e;

endpackage : wdog_pkg

// ---- hdl/wdog_sync2.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Two-stage synchroniser for asynchronous pin inputs
// ----------------------------------------------------------------------
module wdog_sync2 #(
  parameter int WIDTH = 1                  // Number of bits synchronised
) (
  input  wire logic             clk_in,    // System clock
  input  wire logic             rst_b_in,  // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // Asynchronous inputs
  output logic      [WIDTH-1:0] sync_out   // Synchronised outputs
);

  logic [WIDTH-1:0] meta_q;  // First stage, read by the second only
  logic [WIDTH-1:0] sync_q;  // Second stage, safe to use

  // Both stages clear to zero so inputs read inactive during reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : wdog_sync2

// ---- hdl/wdog_tick_gen.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Time-base tick generator: one-cycle pulse every CYCLES clocks
// ----------------------------------------------------------------------
module wdog_tick_gen #(
  parameter int CYCLES = 100000            // Clocks per tick
) (
  input  wire logic clk_in,                // System clock
  input  wire logic rst_b_in,              // Asynchronous reset, active low
  input  wire logic restart_in,            // Restart the tick phase
  output logic      tick_out               // One-cycle tick pulse
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] div_q;   // Divider count
  logic [CW-1:0] div_d;
  logic          tick_q;  // Registered tick
  logic          tick_d;

  // Next divider value; restart aligns ticks to the start of an interval
  always_comb begin
    div_d  = div_q + CW'(1);
    tick_d = 1'b0;
    if (restart_in) begin
      div_d = '0;
    end else if (div_q >= LAST) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  // Register the divider
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule : wdog_tick_gen

// ---- verification/pulse_programmed_watchdog_tb_top.sv ----
`timescale 1ns/100ps

module pulse_programmed_watchdog_tb_top;
  // Short tick keeps the run brief; expectations scale from it
  localparam int TCK  = 4;  // Clocks per tick
  localparam int MAXT = 20; // Maximum timeout, ticks
  localparam int THR  = 3;  // Program threshold, ticks
  localparam int PUL  = 2;  // Reset pulse, ticks
  localparam int CW   = 16; // Counter width

  logic          mclk;       // Clock
  logic          rst_b;      // Power-on reset
  logic          refresh;    // Refresh from host
  logic          inhibit;    // Inhibit from host
  logic          reset_b;    // Reset to host
  logic          programmed; // Programmed flag
  logic [CW-1:0] reload;     // Stored reload value
  int            error_cnt;  // Mismatches
  int            comparisons;// Comparisons made
  int            w;          // Programmed width, ticks
  int            n;          // Measured cycles

  wdog_core #(.TICK_CYCLES(TCK), .CNT_W(CW), .MAX_TIMEOUT(MAXT), .PROG_THRESH(THR),
              .RESET_PULSE(PUL)) uut (
    .MCLK_IN(mclk), .RST_B_IN(rst_b), .WD_REFRESH_IN(refresh), .WD_INHIBIT_IN(inhibit),
    .RESET_B_OUT(reset_b), .PROGRAMMED_OUT(programmed), .RELOAD_OUT(reload));

  wdog_host_model host (
    .clk_in(mclk), .rst_b_in(reset_b), .refresh_out(refresh), .inhibit_out(inhibit));

  // ----------------------------------------------------------------------
  // Clock, compare and wait helpers
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Reload expected after a pulse of t ticks
  function automatic int exp_reload(input int t, input int cur, input bit locked);
    return (!locked && t > THR && t < MAXT) ? t : cur;
  endfunction : exp_reload

  task automatic check_val(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_win(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_win

  // Cycles until the host reset falls, bounded by lim
  task automatic cycles_to_low(input int lim, output int c);
    c = 0;
    while (reset_b !== 1'b0 && c < lim) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask : cycles_to_low

  // Cycles until the host reset rises, bounded
  task automatic wait_high(output int c);
    c = 0;
    while (reset_b !== 1'b1 && c < 200) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask : wait_high

  task automatic test_done(input int k);
    $display("test %0d done", k);
  endtask : test_done

  task automatic end_of_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, well past the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    error_cnt   = 0;
    comparisons = 0;
    rst_b       = 1'b0;
    n           = $urandom(32'h6157);
    w           = 6 + int'($urandom % 14);
    @(posedge mclk);
    #1;
    check_val(reload, CW'(MAXT));
    check_val(CW'(programmed), '0);
    check_val(CW'(reset_b), '0);
    @(posedge mclk);
    rst_b <= 1'b1;
    wait_high(n);
    check_win(n, PUL * TCK, PUL * TCK + 8);
    test_done(1);
    // Pulse at the threshold must not program
    host.pulse(THR * TCK + 2, 4 * TCK);
    check_val(reload, CW'(exp_reload(THR, MAXT, 1'b0)));
    check_val(CW'(programmed), '0);
    test_done(2);
    // First wide pulse programs
    host.pulse(w * TCK + 2, 2 * TCK);
    check_val(reload, CW'(exp_reload(w, MAXT, 1'b0)));
    check_val(CW'(programmed), CW'(1));
    host.pulse((w - 1) * TCK + 2, 2 * TCK);
    check_val(reload, CW'(exp_reload(w - 1, w, 1'b1)));
    test_done(3);
    // Random refresh traffic, gaps below the programmed limit
    for (int i = 0; i < 6; i++) begin
      host.pulse(int'($urandom % (w - 1) + 1) * TCK + 2, int'($urandom % (w - 2) + 1) * TCK);
      check_val(CW'(reset_b), CW'(1));
    end
    check_val(reload, CW'(w));
    test_done(4);
    // Inhibit: long silence without a reset
    host.set_inhibit(1'b1);
    cycles_to_low(3 * w * TCK, n);
    check_win(n, 3 * w * TCK, 3 * w * TCK);
    host.pulse(TCK + 2, 0);
    host.set_inhibit(1'b0);
    test_done(5);
    // Timeout after the last fall, then reload restored
    cycles_to_low(2 * MAXT * TCK, n);
    check_win(n, w * TCK - 2, w * TCK + 8);
    #1;
    check_val(reload, CW'(MAXT));
    check_val(CW'(programmed), '0);
    wait_high(n);
    check_win(n, PUL * TCK, PUL * TCK + 4);
    test_done(6);
    // Pulse of maximum width: no program, no reset
    host.pulse(MAXT * TCK + 2, 2 * TCK);
    check_val(CW'(programmed), '0);
    check_val(CW'(reset_b), CW'(1));
    test_done(7);
    // Refresh stuck high
    fork
      host.pulse(4 * MAXT * TCK, 0);
      begin
        @(posedge mclk);
        #1;
        cycles_to_low(4 * MAXT * TCK, n);
      end
    join
    check_win(n, (MAXT + 1) * TCK, (MAXT + 1) * TCK + 8);
    wait_high(n);
    test_done(8);
    // Power reset in mid-run clears programming
    host.pulse(w * TCK + 2, 2 * TCK);
    check_val(CW'(programmed), CW'(1));
    @(posedge mclk);
    rst_b <= 1'b0;
    @(posedge mclk);
    #1;
    check_val(reload, CW'(MAXT));
    check_val(CW'(programmed), '0);
    // Second release: the power-on reset pulse repeats
    @(posedge mclk);
    rst_b <= 1'b1;
    wait_high(n);
    check_win(n, PUL * TCK, PUL * TCK + 8);
    check_val(reload, CW'(MAXT));
    test_done(9);
    end_of_test();
  end
endmodule : pulse_programmed_watchdog_tb_top

// ---- verification/wdog_host_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Host model: drives the refresh and inhibit lines
// ----------------------------------------------------------------------
module wdog_host_model (
  input  wire logic clk_in,      // System clock
  input  wire logic rst_b_in,    // Reset from the watchdog, active low
  output logic      refresh_out, // Refresh line to the watchdog
  output logic      inhibit_out  // Inhibit line to the watchdog
);
  logic refresh_q; // Requested refresh level

  // refresh dropped on reset
  // Gating by the reset keeps the host out of a reset loop
  assign refresh_out = refresh_q & rst_b_in;

  // Idle lines at time zero
  initial begin
    refresh_q   = 1'b0;
    inhibit_out = 1'b0;
  end

  // refresh pulse, ends early on reset
  // Gap length is chosen by the caller, so slow hosts are possible
  task automatic pulse(input int hi, input int lo);
    int n;
    n = 0;
    @(posedge clk_in);
    refresh_q <= 1'b1;
    while (n < hi && rst_b_in === 1'b1) begin
      @(posedge clk_in);
      n++;
    end
    refresh_q <= 1'b0;
    repeat (lo) @(posedge clk_in);
    #1;
  endtask : pulse

  // inhibit only when a test asks for it
  task automatic set_inhibit(input logic v);
    @(posedge clk_in);
    inhibit_out <= v;
    #1;
  endtask : set_inhibit
endmodule : wdog_host_model
